// File: core/doc_regs.svh
// Purpose: Named constants of the directional overcurrent stage
// Assumes: 50 MHz processing clock, measurement tick every 5 ms
// Notes: Angles in 0.1 deg, currents in 0.01 x In, voltage in 10 mV
//==============================================================
// Overview of operation
// - Up to four stages exist; a stage works only with voltage and current fitted.
// - Phase magnitude selectable: fundamental RMS, true RMS or peak-to-peak.
// - Settings, blocking and active group change while running, no restart.
// - Eight setting groups, active group picked by one common selector.
// - Instant, fixed-time or inverse-time operation with custom curve factor.
// - Transformer saturation check keeps start and trip correct while clipping.
// - Three phases evaluated together as one three-pole function.
// - Start, trip, blocked outputs; time-stamped ON and OFF event per transition.
// - Instant mode issues start and trip events with one time stamp when direction is off or the angle is already in sector.
// - Event time stamps count in one millisecond steps.
// - Separate clearable cumulative counters of start, trip and blocked.
// - True RMS magnitude covers all 32 harmonic spectrum components.
// - Peak-to-peak magnitude taken directly from raw sample stream.
// - Pre-fault value is 20 ms average ending 20 ms before start or trip.
// - Fault angle is positive sequence current against voltage phase.
// - Line-to-line only wiring uses faulty phase line-to-line voltage angle.
// - Voltage under 1 V in fault: memory angle 0.5 s, then zero.
// - Monitored analog input channel set chosen by a setting.
// - Pick-up when any phase exceeds setting; release below 97 percent.
// - On pick-up assert start if unblocked, otherwise assert blocked.
// - Directional trip needs angle in sector; 2 degree reset hysteresis.
// - Memory angle is the value taken 100 ms before fault start.
`ifndef DOC_REGS_SVH
`define DOC_REGS_SVH

`define DOC_NUM_STAGES 4
`define DOC_NGROUP 8
`define DOC_GRP_W 3

`define DOC_CLK_KHZ 50000
`define DOC_TS_RES_MS 1
`define DOC_MS_CYCLES (`DOC_CLK_KHZ * `DOC_TS_RES_MS)
`define DOC_TICK_MS 5
`define DOC_ANG_MEM_MS 100
`define DOC_ANG_HIST (`DOC_ANG_MEM_MS / `DOC_TICK_MS)
`define DOC_PREF_MS 20
`define DOC_PREF_N (`DOC_PREF_MS / `DOC_TICK_MS)
`define DOC_MEM_HOLD_MS 500

`define DOC_RESET_PCT 32'h0000_0061
`define DOC_FULL_PCT 32'h0000_0064
`define DOC_HYST_DDEG 16'h0014
`define DOC_UMIN 16'h0064
`define DOC_HALF_TURN 16'sh0708
`define DOC_FULL_TURN 16'sh0e10
`define DOC_SAT_LEVEL 16'sh7f00
`define DOC_SAT_SH1 2
`define DOC_SAT_SH2 3
`define DOC_INV_SH 8
`define DOC_SMP_MAX 16'sh7fff
`define DOC_SMP_MIN 16'sh8000

`define DOC_DEF_PICKUP 16'h0078
`define DOC_DEF_HALF 11'h370
`define DOC_DEF_CENTER 13'sh0000
`define DOC_DEF_DELAY 16'h0064

`endif

// File: core/doc_pkg.sv
// Purpose: Types shared by the directional overcurrent stage
// Assumes: Constants come from doc_regs.svh
// Notes: Angles signed 0.1 deg, magnitudes unsigned
package doc_pkg;
	typedef logic [15:0] doc_mag_t;
	typedef logic signed [12:0] doc_ang_t;
	typedef logic signed [15:0] doc_smp_t;
	typedef enum logic [1:0] {DOC_MSEL_RMS, DOC_MSEL_TRUE, DOC_MSEL_PP} doc_msel_t;
	typedef enum logic [1:0] {DOC_MODE_INST, DOC_MODE_FIX, DOC_MODE_INV} doc_mode_t;
	typedef enum logic [1:0] {DOC_REF_LIVE, DOC_REF_MEM, DOC_REF_ZERO} doc_ref_t;
	typedef struct packed {
		doc_mag_t [2:0] rms;
		doc_mag_t [2:0] true_rms_magnitude;
	} doc_curr_t;
	typedef struct packed {
		doc_mag_t u1_mag;
		doc_ang_t u1_ang;
		doc_ang_t ll_ang;
		doc_ang_t i1_ang;
		logic ll_only;
	} doc_volt_t;
	typedef struct packed {
		doc_mag_t pickup;
		logic dir_en;
		logic [10:0] half;
		doc_ang_t center;
		doc_mode_t mode;
		logic [15:0] delay;
	} doc_set_t;
	typedef struct packed {
		logic [1:0] stage;
		logic [2:0] on;
		logic [2:0] off;
		logic [31:0] ts;
	} doc_evt_t;
	typedef struct packed {
		logic [15:0] start;
		logic [15:0] trip;
		logic [15:0] blk;
	} doc_cnt_t;
endpackage

// File: core/doc_setmem.sv
// Purpose: Setting group memory, one word per group
// Assumes: Read data registered, one cycle after the group select
// Notes: All groups load defaults at reset
`timescale 1ns/1ps
`include "doc_regs.svh"
module doc_setmem import doc_pkg::*; #(
	parameter int NGRP = `DOC_NGROUP,
	parameter int GW = `DOC_GRP_W
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [GW-1:0] waddr_i,
	input wire doc_set_t wdata_i,
	input wire logic [GW-1:0] raddr_i,
	output doc_set_t rdata_o
);
	typedef struct packed {
		doc_set_t [NGRP-1:0] mem;
		doc_set_t rd;
	} doc_mem_st_t;

	localparam doc_set_t DEF_SET = '{pickup: `DOC_DEF_PICKUP, dir_en: 1'b1,
		half: `DOC_DEF_HALF, center: `DOC_DEF_CENTER, mode: DOC_MODE_FIX,
		delay: `DOC_DEF_DELAY};

	doc_mem_st_t st_ff;
	doc_mem_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (we_i) begin
			nxt_st.mem[waddr_i] = wdata_i;
		end
		nxt_st.rd = st_ff.mem[raddr_i];
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_ff <= {(NGRP + 1){DEF_SET}};
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign rdata_o = st_ff.rd;
endmodule

// File: core/doc_stage.sv
// Purpose: One directional overcurrent stage
// Assumes: meas_valid_i pulses once per 5 ms measurement update
// Notes: Peak-to-peak and saturation use the previous sample window
`timescale 1ns/1ps
`include "doc_regs.svh"
module doc_stage import doc_pkg::*; #(
	parameter int MS_CYCLES = `DOC_MS_CYCLES,
	parameter logic [1:0] STAGE_ID = 2'h0
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic volt_mod_fitted_i,
	input wire logic curr_mod_fitted_i,
	input wire logic chan_sel_i,
	input wire logic meas_valid_i,
	input wire doc_curr_t [1:0] meas_set_i,
	input wire logic sample_valid_i,
	input wire doc_smp_t [1:0][2:0] samples_i,
	input wire doc_volt_t volt_i,
	input wire doc_msel_t msel_i,
	input wire logic block_i,
	input wire logic [`DOC_GRP_W-1:0] grp_sel_i,
	input wire logic set_we_i,
	input wire logic [`DOC_GRP_W-1:0] set_grp_i,
	input wire doc_set_t set_wdata_i,
	input wire logic [2:0] cnt_clr_i,
	output logic start_o,
	output logic trip_o,
	output logic blocked_o,
	output logic evt_valid_o,
	output doc_evt_t evt_o,
	output doc_cnt_t cnt_o,
	output doc_mag_t prefault_o,
	output doc_ang_t fault_ang_o
);
	typedef struct packed {
		doc_ref_t ref_st;
		logic picked;
		logic start;
		logic trip;
		logic blocked;
		logic in_sec;
		logic sat;
		logic sat_win;
		logic [31:0] ms_div;
		logic [31:0] ts;
		logic [15:0] dly;
		logic [31:0] acc;
		logic [15:0] mem_cnt;
		doc_ang_t mem_ang;
		doc_ang_t [`DOC_ANG_HIST-1:0] ang_hist;
		doc_mag_t [2*`DOC_PREF_N-1:0] mag_hist;
		doc_smp_t [2:0] pp_max;
		doc_smp_t [2:0] pp_min;
		doc_mag_t [2:0] pp_val;
		logic evt_valid;
		doc_evt_t evt;
		doc_cnt_t cnt;
		doc_mag_t prefault;
		doc_ang_t fault_ang;
	} doc_st_t;

	doc_st_t st_ff;
	doc_st_t nxt_st;
	doc_set_t cur;
	doc_curr_t meas;
	doc_smp_t [2:0] smp;
	doc_mag_t [2:0] mag;
	logic [2:0] over;
	logic [2:0] below;
	logic active;
	logic ms_tick;
	logic u_low;
	doc_ang_t live_ang;
	doc_ang_t ref_ang;
	doc_ang_t diff;
	logic [15:0] abs_d;

	//==============================================================
	// Helpers
	function automatic doc_ang_t wrap_ang(input logic signed [15:0] x);
		logic signed [15:0] y;
		y = x;
		if (y > `DOC_HALF_TURN) begin
			y = y - `DOC_FULL_TURN;
		end else if (y < -`DOC_HALF_TURN) begin
			y = y + `DOC_FULL_TURN;
		end
		return doc_ang_t'(y);
	endfunction

	function automatic logic is_below(input doc_mag_t m, input doc_mag_t pk);
		return (32'(m) * `DOC_FULL_PCT) < (32'(pk) * `DOC_RESET_PCT);
	endfunction

	function automatic doc_mag_t pp_span(input doc_smp_t mx, input doc_smp_t mn);
		logic signed [16:0] d;
		d = 17'(mx) - 17'(mn);
		if (d < 17'sh00000) begin
			return 16'h0000;
		end else if (d > 17'sh0ffff) begin
			return 16'hffff;
		end
		return d[15:0];
	endfunction

	//==============================================================
	// Setting groups
	doc_setmem #(.NGRP(`DOC_NGROUP), .GW(`DOC_GRP_W)) u_setmem (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.we_i(set_we_i),
		.waddr_i(set_grp_i),
		.wdata_i(set_wdata_i),
		.raddr_i(grp_sel_i),
		.rdata_o(cur)
	);

	//==============================================================
	// Input selection and per-phase comparison
	assign active = volt_mod_fitted_i && curr_mod_fitted_i;
	assign meas = meas_set_i[chan_sel_i];
	assign smp = samples_i[chan_sel_i];
	assign ms_tick = (st_ff.ms_div == 32'(MS_CYCLES - 1));
	assign u_low = volt_i.u1_mag < `DOC_UMIN;

	generate
		for (genvar p = 0; p < 3; p++) begin : g_ph
			doc_mag_t sel;
			doc_mag_t est;
			always_comb begin
				case (msel_i)
				DOC_MSEL_TRUE: sel = meas.true_rms_magnitude[p];
				DOC_MSEL_PP: sel = st_ff.pp_val[p];
				default: sel = meas.rms[p];
				endcase
			end
			assign est = (st_ff.pp_val[p] >> `DOC_SAT_SH1) + (st_ff.pp_val[p] >> `DOC_SAT_SH2);
			assign mag[p] = (st_ff.sat && est > sel) ? est : sel;
			assign over[p] = mag[p] > cur.pickup;
			assign below[p] = is_below(mag[p], cur.pickup);
		end
	endgenerate

	//==============================================================
	// Direction
	assign live_ang = volt_i.ll_only ? volt_i.ll_ang : volt_i.u1_ang;

	always_comb begin
		case (st_ff.ref_st)
		DOC_REF_MEM: ref_ang = st_ff.mem_ang;
		DOC_REF_ZERO: ref_ang = '0;
		default: ref_ang = live_ang;
		endcase
	end

	assign diff = wrap_ang(16'(wrap_ang(16'(volt_i.i1_ang) - 16'(ref_ang))) - 16'(cur.center));
	assign abs_d = (diff < 0) ? 16'(-diff) : 16'(diff);

	//==============================================================
	// Next state
	always_comb begin
		doc_mag_t mx_mag;
		doc_smp_t mx;
		doc_smp_t mn;
		logic dir_ok;
		logic [2:0] rise;
		logic [2:0] fall;
		logic [17:0] sum;
		mx_mag = '0;
		mx = '0;
		mn = '0;
		dir_ok = 1'b0;
		rise = '0;
		fall = '0;
		sum = '0;
		nxt_st = st_ff;
		nxt_st.evt_valid = 1'b0;

		// Millisecond time base
		nxt_st.ms_div = ms_tick ? '0 : st_ff.ms_div + 32'h0000_0001;
		if (ms_tick) begin
			nxt_st.ts = st_ff.ts + 32'h0000_0001;
		end

		// Raw sample window: peak-to-peak and clipping
		for (int p = 0; p < 3; p++) begin
			mx = meas_valid_i ? `DOC_SMP_MIN : st_ff.pp_max[p];
			mn = meas_valid_i ? `DOC_SMP_MAX : st_ff.pp_min[p];
			if (sample_valid_i && smp[p] > mx) begin
				mx = smp[p];
			end
			if (sample_valid_i && smp[p] < mn) begin
				mn = smp[p];
			end
			nxt_st.pp_max[p] = mx;
			nxt_st.pp_min[p] = mn;
			if (meas_valid_i) begin
				nxt_st.pp_val[p] = pp_span(st_ff.pp_max[p], st_ff.pp_min[p]);
			end
			if (mag[p] > mx_mag) begin
				mx_mag = mag[p];
			end
		end
		if (meas_valid_i) begin
			nxt_st.sat = st_ff.sat_win;
			nxt_st.sat_win = 1'b0;
		end
		for (int p = 0; p < 3; p++) begin
			if (sample_valid_i && (smp[p] >= `DOC_SAT_LEVEL || smp[p] <= -`DOC_SAT_LEVEL)) begin
				nxt_st.sat_win = 1'b1;
			end
		end

		// Per-tick evaluation
		if (meas_valid_i) begin
			if (st_ff.ref_st == DOC_REF_LIVE) begin
				nxt_st.ang_hist = {st_ff.ang_hist[`DOC_ANG_HIST-2:0], live_ang};
			end
			nxt_st.mag_hist = {st_ff.mag_hist[2*`DOC_PREF_N-2:0], mx_mag};
			nxt_st.in_sec = 16'(abs_d) <= 16'(cur.half) +
				(st_ff.in_sec ? `DOC_HYST_DDEG : 16'h0000);
			nxt_st.picked = st_ff.picked ? !(&below) : (|over);
			nxt_st.start = nxt_st.picked && !block_i;
			nxt_st.blocked = nxt_st.picked && block_i;
		end
		if (!active) begin
			nxt_st.picked = 1'b0;
			nxt_st.start = 1'b0;
			nxt_st.blocked = 1'b0;
		end

		// Reference angle memory
		case (st_ff.ref_st)
		DOC_REF_LIVE: begin
			if (meas_valid_i && st_ff.picked && u_low) begin
				nxt_st.ref_st = DOC_REF_MEM;
				nxt_st.mem_ang = st_ff.ang_hist[`DOC_ANG_HIST-1];
				nxt_st.mem_cnt = '0;
			end
		end
		DOC_REF_MEM: begin
			if (ms_tick) begin
				nxt_st.mem_cnt = st_ff.mem_cnt + 16'h0001;
				if (st_ff.mem_cnt == 16'(`DOC_MEM_HOLD_MS - 1)) begin
					nxt_st.ref_st = DOC_REF_ZERO;
				end
			end
			if (!st_ff.picked || (meas_valid_i && !u_low)) begin
				nxt_st.ref_st = DOC_REF_LIVE;
			end
		end
		DOC_REF_ZERO: begin
			if (!st_ff.picked || (meas_valid_i && !u_low)) begin
				nxt_st.ref_st = DOC_REF_LIVE;
			end
		end
		default: nxt_st.ref_st = DOC_REF_LIVE;
		endcase

		// Operate time
		dir_ok = !cur.dir_en || nxt_st.in_sec;
		if (!nxt_st.start || !dir_ok) begin
			nxt_st.dly = '0;
			nxt_st.acc = '0;
			nxt_st.trip = 1'b0;
		end else begin
			case (cur.mode)
			DOC_MODE_INST: nxt_st.trip = 1'b1;
			DOC_MODE_INV: begin
				if (meas_valid_i && mx_mag > cur.pickup) begin
					nxt_st.acc = st_ff.acc + 32'(mx_mag - cur.pickup);
				end
				if (nxt_st.acc >= (32'(cur.delay) << `DOC_INV_SH)) begin
					nxt_st.trip = 1'b1;
				end
			end
			default: begin
				if (ms_tick && !st_ff.trip) begin
					nxt_st.dly = st_ff.dly + 16'h0001;
				end
				if (nxt_st.dly >= cur.delay) begin
					nxt_st.trip = 1'b1;
				end
			end
			endcase
		end

		// Events and counters
		rise = {nxt_st.blocked, nxt_st.trip, nxt_st.start} &
			~{st_ff.blocked, st_ff.trip, st_ff.start};
		fall = ~{nxt_st.blocked, nxt_st.trip, nxt_st.start} &
			{st_ff.blocked, st_ff.trip, st_ff.start};
		if (|{rise, fall}) begin
			nxt_st.evt_valid = 1'b1;
			nxt_st.evt.stage = STAGE_ID;
			nxt_st.evt.on = rise;
			nxt_st.evt.off = fall;
			nxt_st.evt.ts = st_ff.ts;
		end
		if (cnt_clr_i[0]) begin
			nxt_st.cnt.start = '0;
		end
		if (cnt_clr_i[1]) begin
			nxt_st.cnt.trip = '0;
		end
		if (cnt_clr_i[2]) begin
			nxt_st.cnt.blk = '0;
		end
		if (rise[0]) begin
			nxt_st.cnt.start = nxt_st.cnt.start + 16'h0001;
		end
		if (rise[1]) begin
			nxt_st.cnt.trip = nxt_st.cnt.trip + 16'h0001;
		end
		if (rise[2]) begin
			nxt_st.cnt.blk = nxt_st.cnt.blk + 16'h0001;
		end

		// Pre-fault average and fault angle
		if (rise[0] || rise[1]) begin
			for (int k = `DOC_PREF_N; k < 2 * `DOC_PREF_N; k++) begin
				sum = sum + 18'(st_ff.mag_hist[k]);
			end
			nxt_st.prefault = 16'(sum / `DOC_PREF_N);
			nxt_st.fault_ang = meas_valid_i ? diff : st_ff.fault_ang;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign start_o = st_ff.start;
	assign trip_o = st_ff.trip;
	assign blocked_o = st_ff.blocked;
	assign evt_valid_o = st_ff.evt_valid;
	assign evt_o = st_ff.evt;
	assign cnt_o = st_ff.cnt;
	assign prefault_o = st_ff.prefault;
	assign fault_ang_o = st_ff.fault_ang;

	//==============================================================
	// Checks
	AST_START_XOR_BLOCK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(start_o && blocked_o)) else $error("start and blocked high together");

	AST_TRIP_NEEDS_START: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		trip_o |-> start_o) else $error("trip without start");

	AST_INSTANT_SAME_STAMP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(start_o) && $past(cur.mode) == DOC_MODE_INST && $past(!cur.dir_en)
		|-> trip_o && evt_o.on[1] && evt_o.on[0]) else $error("instant trip not with start");

	AST_START_EVENT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(start_o) |-> evt_valid_o && evt_o.on[0] && evt_o.ts == $past(st_ff.ts))
		else $error("start rise without stamped event");

	AST_TRIP_COUNT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(trip_o) && !$past(cnt_clr_i[1]) |-> cnt_o.trip == $past(cnt_o.trip) + 16'h0001)
		else $error("trip counter not advanced");

	AST_BLOCK_CLEAR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && cnt_clr_i[2] && !(nxt_st.blocked && !st_ff.blocked) |=> cnt_o.blk == 16'h0000)
		else $error("blocked counter not cleared");

	AST_RELEASE_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && active && meas_valid_i && st_ff.picked && !(&below) |=> st_ff.picked)
		else $error("pick-up released above reset ratio");

	AST_NO_PICK_BELOW: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && meas_valid_i && !st_ff.picked && !(|over) |=> !st_ff.picked)
		else $error("pick-up without overcurrent");

	AST_TICK_ONLY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && active && !meas_valid_i |=> $stable(start_o) && $stable(blocked_o))
		else $error("start or blocked changed between ticks");

	AST_MS_STAMP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && ms_tick |=> st_ff.ts == $past(st_ff.ts) + 32'h0000_0001)
		else $error("time stamp did not advance");

	AST_MEM_TO_ZERO: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && st_ff.ref_st == DOC_REF_MEM && ms_tick && st_ff.picked && !meas_valid_i &&
		st_ff.mem_cnt == 16'(`DOC_MEM_HOLD_MS - 1) |=> st_ff.ref_st == DOC_REF_ZERO)
		else $error("angle memory not ended at hold time");

	AST_INACTIVE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && !active |=> !start_o && !trip_o && !blocked_o)
		else $error("stage active without both modules");

	COV_FIX_TRIP: cover property (@(posedge ref_clk_i) $rose(trip_o) && cur.mode == DOC_MODE_FIX);
	COV_INV_TRIP: cover property (@(posedge ref_clk_i) $rose(trip_o) && cur.mode == DOC_MODE_INV);
	COV_BLOCKED: cover property (@(posedge ref_clk_i) $rose(blocked_o));
	COV_REF_ZERO: cover property (@(posedge ref_clk_i) st_ff.ref_st == DOC_REF_ZERO);
endmodule

// File: testbench/doc_frontend_model.sv
// Purpose: Measurement front end model feeding one overcurrent stage
// Assumes: One measurement tick every TICK cycles, one raw sample every cycle
// Notes: Outside the tick cycle the data is inverted so that stale values show
`timescale 1ns/1ps
module doc_frontend_model import doc_pkg::*; #(
	parameter int TICK = 50
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire doc_curr_t [1:0] cmd_set_i,
	input wire doc_smp_t amp_i,
	input wire doc_volt_t cmd_volt_i,
	output logic meas_valid_o,
	output doc_curr_t [1:0] meas_set_o,
	output logic sample_valid_o,
	output doc_smp_t [1:0][2:0] samples_o,
	output doc_volt_t volt_o
);
	int cnt = 0;
	logic sgn = 1'b0;
	logic tk;
	doc_smp_t s;
	assign tk = (cnt == TICK - 1);
	assign s = sgn ? amp_i : -amp_i;
	initial begin
		meas_valid_o = 1'b0;
		meas_set_o = '0;
		sample_valid_o = 1'b0;
		samples_o = '0;
		volt_o = '0;
	end
	//==============================================================
	// Tick, magnitudes and raw samples
	always @(posedge ref_clk_i) begin
		cnt <= (sys_rst_i || tk) ? 0 : cnt + 1;
		meas_valid_o <= tk && !sys_rst_i;
		meas_set_o <= tk ? cmd_set_i : ~cmd_set_i;
		volt_o <= tk ? cmd_volt_i : ~cmd_volt_i;
		sgn <= ~sgn;
		sample_valid_o <= !sys_rst_i;
		samples_o <= {6{s}};
	end
endmodule

// File: testbench/directional_overcurrent_stage_tb.sv
// Purpose: Self-checking bench for one directional overcurrent stage
// Assumes: Tick every 50 cycles, 10 cycles per millisecond
// Notes: Bench inputs change on the falling edge
`timescale 1ns/1ps
module directional_overcurrent_stage_tb import doc_pkg::*; ;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic vfit = 1'b1, cfit = 1'b1, chan = 1'b0, blk = 1'b0, we = 1'b0;
	doc_msel_t msel = DOC_MSEL_RMS;
	logic [2:0] grp = 3'h0, wgrp = 3'h0, clr = 3'h0;
	doc_set_t wdata = '0;
	doc_curr_t [1:0] cset = '0;
	doc_smp_t amp = 16'sh0000;
	doc_volt_t vc = '0;
	logic mv, sv, evt_valid, start, trip, blocked;
	doc_curr_t [1:0] mset;
	doc_smp_t [1:0][2:0] smp;
	doc_volt_t volt;
	doc_evt_t evt;
	doc_cnt_t cnt;
	doc_mag_t pref;
	doc_ang_t fang;
	logic [2:0] outs;
	int miscompares = 0, checked = 0;
	logic [12:0] angs [5] = '{13'h0000, 13'h0385, 13'h037a, 13'h0370, 13'h037a};
	logic [2:0] exps [5] = '{3'h3, 3'h1, 3'h1, 3'h3, 3'h3};
	assign outs = {blocked, trip, start};
	always #10 ref_clk_i = ~ref_clk_i;

	doc_frontend_model #(.TICK(50)) fe (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.cmd_set_i(cset), .amp_i(amp), .cmd_volt_i(vc), .meas_valid_o(mv),
		.meas_set_o(mset), .sample_valid_o(sv), .samples_o(smp), .volt_o(volt));
	doc_stage #(.MS_CYCLES(10), .STAGE_ID(2'h2)) dut (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .ce_i(1'b1), .volt_mod_fitted_i(vfit),
		.curr_mod_fitted_i(cfit), .chan_sel_i(chan), .meas_valid_i(mv), .meas_set_i(mset),
		.sample_valid_i(sv), .samples_i(smp), .volt_i(volt), .msel_i(msel), .block_i(blk),
		.grp_sel_i(grp), .set_we_i(we), .set_grp_i(wgrp), .set_wdata_i(wdata),
		.cnt_clr_i(clr), .start_o(start), .trip_o(trip), .blocked_o(blocked),
		.evt_valid_o(evt_valid), .evt_o(evt), .cnt_o(cnt), .prefault_o(pref),
		.fault_ang_o(fang));

	//==============================================================
	// Compare, access and closing tasks
	task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t outputs got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t value got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic doc_set_t mk(input doc_mag_t p, input logic d, input doc_mode_t m,
		input logic [15:0] dl);
		mk = '{pickup: p, dir_en: d, half: 11'h370, center: 13'sh0000, mode: m, delay: dl};
	endfunction
	task automatic wr_set(input logic [2:0] g, input doc_set_t s);
		we = 1'b1;
		wgrp = g;
		wdata = s;
		@(negedge ref_clk_i);
		we = 1'b0;
	endtask
	task automatic tick(input doc_mag_t m);
		cset[0].rms[0] = m;
		@(posedge ref_clk_i iff mv);
		@(negedge ref_clk_i);
	endtask
	task automatic give_verdict();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		miscompares++;
		give_verdict();
	end

	//==============================================================
	// Test sequence
	initial begin
		vc.u1_mag = 16'h03e8;
		repeat (8) @(negedge ref_clk_i);
		chk_out(outs, 3'h0);
		chk_val(cnt, 48'h0);
		sys_rst_i = 1'b0;
		wr_set(3'h0, mk(16'h0078, 1'b0, DOC_MODE_INST, 16'h0000));
		tick(16'h0079);
		chk_out(outs, 3'h3);
		chk_val(evt_valid, 48'h1);
		chk_val(evt.on, 48'h3);
		chk_val(evt.stage, 48'h2);
		chk_val(evt.ts, 48'h5);
		chk_val(cnt, {16'h1, 16'h1, 16'h0});
		$display("test instant done");
		tick(16'h0075);
		chk_out(outs, 3'h3);
		tick(16'h0074);
		chk_out(outs, 3'h0);
		chk_val(evt.off, 48'h3);
		tick(16'h0078);
		chk_out(outs, 3'h0);
		$display("test hysteresis done");
		blk = 1'b1;
		tick(16'h0079);
		chk_out(outs, 3'h4);
		chk_val(evt.on, 48'h4);
		blk = 1'b0;
		tick(16'h0079);
		chk_out(outs, 3'h3);
		blk = 1'b1;
		tick(16'h0079);
		chk_out(outs, 3'h4);
		tick(16'h0000);
		blk = 1'b0;
		chk_val(cnt, {16'h2, 16'h2, 16'h2});
		clr = 3'h1;
		@(negedge ref_clk_i);
		clr = 3'h0;
		chk_val(cnt, {16'h0, 16'h2, 16'h2});
		clr = 3'h6;
		@(negedge ref_clk_i);
		clr = 3'h0;
		chk_val(cnt, 48'h0);
		$display("test blocking done");
		wr_set(3'h5, mk(16'h0200, 1'b0, DOC_MODE_INST, 16'h0000));
		grp = 3'h5;
		tick(16'h0079);
		chk_out(outs, 3'h0);
		tick(16'h0201);
		chk_out(outs, 3'h3);
		grp = 3'h0;
		tick(16'h0079);
		chk_out(outs, 3'h3);
		tick(16'h0000);
		grp = 3'h7;
		tick(16'h0079);
		chk_out(outs, 3'h1);
		tick(16'h0000);
		$display("test groups done");
		wr_set(3'h1, mk(16'h0078, 1'b0, DOC_MODE_FIX, 16'h0002));
		grp = 3'h1;
		tick(16'h0079);
		chk_out(outs, 3'h1);
		repeat (30) @(negedge ref_clk_i);
		chk_out(outs, 3'h3);
		tick(16'h0000);
		wr_set(3'h1, mk(16'h0078, 1'b0, DOC_MODE_INV, 16'h0001));
		tick(16'h00f8);
		chk_out(outs, 3'h1);
		repeat (2) tick(16'h00f8);
		chk_out(outs, 3'h3);
		tick(16'h0000);
		$display("test delays done");
		wr_set(3'h2, mk(16'h0078, 1'b1, DOC_MODE_INST, 16'h0000));
		grp = 3'h2;
		for (int i = 0; i < 5; i++) begin
			vc.i1_ang = angs[i];
			tick(16'h0079);
			chk_out(outs, exps[i]);
		end
		chk_val(fang, 48'h370);
		vc.i1_ang = 13'sh0000;
		vc.ll_only = 1'b1;
		vc.ll_ang = 13'sh0385;
		tick(16'h0079);
		chk_out(outs, 3'h1);
		vc.ll_only = 1'b0;
		tick(16'h0000);
		$display("test direction done");
		vc.u1_ang = 13'sh0385;
		vc.i1_ang = 13'sh0385;
		repeat (20) tick(16'h0000);
		vc.u1_mag = 16'h0032;
		vc.u1_ang = 13'sh1c7c;
		repeat (2) tick(16'h0079);
		chk_out(outs, 3'h1);
		tick(16'h0079);
		chk_out(outs, 3'h3);
		repeat (98) tick(16'h0079);
		chk_out(outs, 3'h3);
		tick(16'h0079);
		chk_out(outs, 3'h1);
		vc.u1_mag = 16'h03e8;
		vc.u1_ang = 13'sh0000;
		vc.i1_ang = 13'sh0000;
		tick(16'h0000);
		$display("test angle memory done");
		grp = 3'h0;
		cset[0].rms[2] = 16'h0200;
		msel = DOC_MSEL_TRUE;
		tick(16'h0000);
		chk_out(outs, 3'h0);
		msel = DOC_MSEL_RMS;
		tick(16'h0000);
		chk_out(outs, 3'h3);
		chan = 1'b1;
		tick(16'h0000);
		chk_out(outs, 3'h0);
		cset[1].true_rms_magnitude[1] = 16'h0200;
		msel = DOC_MSEL_TRUE;
		tick(16'h0000);
		chk_out(outs, 3'h3);
		cset = '0;
		chan = 1'b0;
		msel = DOC_MSEL_PP;
		amp = 16'sh0100;
		repeat (2) tick(16'h0000);
		chk_out(outs, 3'h3);
		amp = 16'sh0000;
		repeat (3) tick(16'h0000);
		chk_out(outs, 3'h0);
		msel = DOC_MSEL_RMS;
		amp = 16'sh7f00;
		repeat (2) tick(16'h0000);
		chk_out(outs, 3'h3);
		amp = 16'sh0000;
		repeat (3) tick(16'h0000);
		chk_out(outs, 3'h0);
		$display("test magnitude select done");
		repeat (8) tick(16'h0060);
		tick(16'h0079);
		chk_val(pref, 48'h60);
		cfit = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk_out(outs, 3'h0);
		cfit = 1'b1;
		tick(16'h0000);
		$display("test prefault and fitting done");
		give_verdict();
	end
endmodule
